// [inc/baud_sel_pkg.sv]
// Shared constants and carriers for the serial baud source selection block.
// Assumes a single 200 MHz system clock domain and an APB register slave.
package baud_sel_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TMR_MODE  = 8'h00;  // timer_mode_reg
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h04;  // power_control_reg
  localparam logic [7:0] ADDR_T1_CTRL   = 8'h08;  // Timer 1 run/prescale
  localparam logic [7:0] ADDR_T2_CTRL   = 8'h0c;  // timer2_control_reg
  localparam logic [7:0] ADDR_T2_CAP    = 8'h10;  // capture high/low
  localparam logic [7:0] ADDR_UART_CTRL = 8'h14;  // mode, ninth bit, brg sel
  localparam logic [7:0] ADDR_STATUS    = 8'h18;  // live state

  // Field positions
  localparam int DOUBLER_BIT  = 7;  // baud_doubler in power_control_reg
  localparam int T2_TXSEL_BIT = 4;  // t2_tx_clock_sel
  localparam int T2_RXSEL_BIT = 5;  // receive clock select
  localparam int T2_RUN_BIT   = 2;
  localparam int T1_MODE_LSB  = 4;  // upper nibble of timer_mode_reg
  localparam int T1_RUN_BIT   = 0;
  localparam int T1_EXT_BIT   = 1;  // count external events
  localparam int TPS_LSB      = 4;
  localparam int NINTH_BIT    = 0;
  localparam int SMODE_LSB    = 1;
  localparam int BRG_TX_BIT   = 3;
  localparam int BRG_RX_BIT   = 4;

  // Fixed dividers
  localparam logic [4:0] DIV_MODE0 = 5'h03;  // divide by 4
  localparam logic [4:0] DIV_ASYNC = 5'h1f;  // divide by 32
  localparam logic [4:0] DIV_T2    = 5'h0f;  // divide by 16

  // Timer 1 mode-2 upper nibble and serial mode codes
  localparam logic [3:0] T1_AUTO_RELOAD = 4'h2;
  localparam logic [1:0] SMODE_0 = 2'h0;
  localparam logic [1:0] SMODE_1 = 2'h1;
  localparam logic [1:0] SMODE_3 = 2'h3;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Configuration gathered from the register file
  typedef struct packed {
    logic [3:0]  t1_mode_nib;
    logic        t1_run;
    logic        t1_ext;
    logic [2:0]  prescale;
    logic        doubler;
    logic        t2_run;
    logic        t2_tx_sel;
    logic        t2_rx_sel;
    logic [15:0] t2_cap;
    logic        ninth_tx_bit;
    logic [1:0]  serial_mode;
    logic        brg_tx_sel;
    logic        brg_rx_sel;
  } baud_cfg_t;

  // Selected clock source per direction
  typedef enum logic [1:0] {SRC_FIXED, SRC_T1, SRC_T2, SRC_BRG} src_t;

endpackage : baud_sel_pkg

// [src/baud_timer_core.sv]
// Timer 1 (modes 0..2) and Timer 2 baud-generator counter.
// Assumes events are already synchronised to mclk.
`timescale 1ns/1ps
module baud_timer_core
  import baud_sel_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Configuration and external count event
  input  wire baud_cfg_t  cfg,
  input  wire logic       t1_event,
  // Overflow pulses
  output logic            t1_ovf,
  output logic            t2_ovf
);

  typedef struct packed {
    logic [2:0]  pre;
    logic [15:0] t1;
    logic [15:0] t2;
    logic        t1_ovf;
    logic        t2_ovf;
  } core_st_t;

  core_st_t st_r, st_nxt;
  logic     tick;

  // Next state: prescaled Timer 1 tick, unscaled Timer 2 rollover
  always_comb begin
    st_nxt        = st_r;
    st_nxt.t1_ovf = 1'b0;
    st_nxt.t2_ovf = 1'b0;
    tick          = 1'b0;
    if (cfg.t1_ext) begin
      tick = t1_event;                      // Counter operation
    end else if (st_r.pre >= cfg.prescale) begin
      tick = 1'b1;                          // Divide by prescale+1
    end
    if (cfg.t1_ext || st_r.pre >= cfg.prescale) begin
      st_nxt.pre = 3'h0;
    end else begin
      st_nxt.pre = st_r.pre + 3'h1;
    end
    if (cfg.t1_run && tick) begin
      case (cfg.t1_mode_nib[1:0])
        2'h2: begin                         // 8-bit auto reload
          if (st_r.t1[7:0] == 8'hff) begin
            st_nxt.t1[7:0] = st_r.t1[15:8];
            st_nxt.t1_ovf  = 1'b1;
          end else begin
            st_nxt.t1[7:0] = st_r.t1[7:0] + 8'h01;
          end
        end
        2'h0: begin                         // 13-bit count
          st_nxt.t1[12:0] = st_r.t1[12:0] + 13'h0001;
          st_nxt.t1_ovf   = (st_r.t1[12:0] == 13'h1fff);
        end
        default: begin                      // 16-bit count
          st_nxt.t1     = st_r.t1 + 16'h0001;
          st_nxt.t1_ovf = (st_r.t1 == 16'hffff);
        end
      endcase
    end
    // Timer 2 ignores prescale and double speed
    if (!cfg.t2_run) begin
      st_nxt.t2 = cfg.t2_cap;
    end else if (st_r.t2 == 16'hffff) begin
      st_nxt.t2     = cfg.t2_cap;           // Reload from capture
      st_nxt.t2_ovf = 1'b1;
    end else begin
      st_nxt.t2 = st_r.t2 + 16'h0001;
    end
  end

  // State register; the reload byte is the Timer 1 high byte, which no bus write reaches
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign t1_ovf = st_r.t1_ovf;
  assign t2_ovf = st_r.t2_ovf;

endmodule : baud_timer_core

// [src/baud_div.sv]
// Divider chain turning a selected overflow pulse into a bit-rate tick.
// Assumes the pulse is one mclk cycle wide.
`timescale 1ns/1ps
module baud_div
  import baud_sel_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Source pulse and terminal count
  input  wire logic       src_pulse,
  input  wire logic [4:0] term,
  // Bit tick
  output logic            bit_tick
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } div_st_t;

  div_st_t st_r, st_nxt;

  // Count source pulses up to the terminal value
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (src_pulse) begin
      if (st_r.cnt >= term) begin
        st_nxt.cnt  = 5'h00;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bit_tick = st_r.tick;

endmodule : baud_div

// [src/uart_baud_timer_select.sv]
// Baud source selection for the serial port: Timer 1, Timer 2 or the
// internal generator feed independent transmit and receive dividers.
// Assumes an APB master on mclk and a generator tick from outside.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module uart_baud_timer_select
  import baud_sel_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External Timer 1 count pin and internal generator tick
  input  wire logic        t1_pin,
  input  wire logic        brg_tick,
  // Bit-rate ticks to the transmitter and receiver
  output logic             tx_bit_tick,
  output logic             rx_bit_tick
);

  ////////////////////////////////////////////////////////////////////////
  // State
  //
  // Register map: one aligned 32-bit word each, unused bits read zero.
  //   00 timer mode      [7:4] Timer 1 mode nibble
  //   04 power control   [7] baud doubler
  //   08 Timer 1 control [0] run, [1] count pin edges, [6:4] prescale
  //   0c Timer 2 control [2] run, [4] tx select, [5] rx select
  //   10 capture         [15:0] Timer 2 reload word
  //   14 serial control  [0] ninth bit, [2:1] mode, [3] gen tx, [4] gen rx
  //   18 status, ro      [1:0] tx source, [3:2] rx source, [4] count pin
  // Source codes: 0 fixed (no tick here), 1 Timer 1, 2 Timer 2,
  // 3 internal generator. Writes to status and to unmapped words
  // change nothing; unmapped words also raise pslverr.
  //
  // Bit periods in mclk cycles, with P the cycles between overflows:
  //   mode 0, ninth bit set   4 P, or 2 P with the doubler
  //   modes 1/3 on Timer 1    32 P, or 16 P with the doubler
  //   modes 1/3 on Timer 2    16 P, doubler ignored
  //   modes 1/3 on generator  32 beats, or 16 beats with the doubler
  //   Timer 1 auto-reload     P = 256 ticks times (prescale + 1)
  //   Timer 2                 P = 65536 - capture
  // Mode 0 with the ninth bit clear runs from a fixed divider that lives
  // outside this block, so no tick comes from here then.
  //
  // Limitation: the Timer 1 reload byte is not writable from the bus.
  // Only 13- and 16-bit counting move it off its reset zero; while zero, auto-reload overflows every 256 Timer 1 ticks.
  // Hazard: a source switched mid-frame leaves a stale divider count,
  // so the first tick after a switch may come early; switch between
  // frames.

  typedef struct packed {
    baud_cfg_t   cfg;
    logic [1:0]  pin_sync;
    logic        pin_prev;
    logic [31:0] rdata;
    logic        slverr;
  } top_st_t;

  top_st_t     st_r, st_nxt;
  logic        t1_ovf, t2_ovf;
  logic        tx_src, rx_src;
  logic [4:0]  tx_term, rx_term;
  src_t        tx_sel, rx_sel;
  logic        acc, wr, rd, hit;
  logic        t1_event;

  // Terminal count from a base divider, halved by the doubler
  // Bases are one less than the divide ratio, so a shift halves the ratio
  function automatic logic [4:0] div_term(input logic [4:0] base,
                                          input logic       dbl);
    div_term = dbl ? (base >> 1) : base;
  endfunction : div_term

  // Decode whether a byte address is mapped
  // Only whole, aligned words decode; byte offsets inside a word miss
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_TMR_MODE) || (a == ADDR_PWR_CTRL) ||
             (a == ADDR_T1_CTRL) || (a == ADDR_T2_CTRL) ||
             (a == ADDR_T2_CAP) || (a == ADDR_UART_CTRL) ||
             (a == ADDR_STATUS);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: zero wait states, answer in the access phase
  //
  // Setup cycle: the address is decoded and read data latched at its
  // edge, so prdata already stands when the access phase begins.
  // Access cycle: pready is always high, a write lands at its edge.
  // The decode is registered so that pslverr does not ripple from paddr.
  // Back-to-back transfers are fine: each setup relatches the decode.

  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign rd       = psel && !penable && !pwrite;
  assign hit      = mapped(paddr);
  assign pready   = 1'b1;
  assign prdata   = st_r.rdata;
  assign pslverr  = acc && st_r.slverr;
  // Rising edge of the synchronised count pin; pin_prev resets low like
  // the idle pin, so no false edge follows reset
  // Pin edges are counted only when Timer 1 is set to count events
  assign t1_event = st_r.pin_sync[1] && !st_r.pin_prev;

  ////////////////////////////////////////////////////////////////////////
  // Source selection per direction
  // Transmit and receive each pick a source and a terminal count, then
  // feed their own divider, so they may run at different rates.
  // In mode 0 both directions share one source and one divider ratio.
  // Generator beats arrive from outside as one-cycle pulses on mclk.

  always_comb begin
    // Generator first, then Timer 2, else Timer 1
    if (st_r.cfg.serial_mode == SMODE_0) begin
      tx_sel = st_r.cfg.ninth_tx_bit ? SRC_T1 : SRC_FIXED;
      rx_sel = tx_sel;
    end else begin
      if (st_r.cfg.brg_tx_sel) begin
        tx_sel = SRC_BRG;
      end else if (st_r.cfg.t2_tx_sel) begin
        tx_sel = SRC_T2;
      end else begin
        tx_sel = SRC_T1;
      end
      if (st_r.cfg.brg_rx_sel) begin
        rx_sel = SRC_BRG;
      end else if (st_r.cfg.t2_rx_sel) begin
        rx_sel = SRC_T2;
      end else begin
        rx_sel = SRC_T1;
      end
    end
  end

  // Pulse and divider per source; mode 0 divides by 4, or by 2 with the doubler
  always_comb begin
    case (tx_sel)
      SRC_T1:  tx_src = t1_ovf;
      SRC_T2:  tx_src = t2_ovf;
      SRC_BRG: tx_src = brg_tick;
      default: tx_src = 1'b0;               // Fixed rate lives elsewhere
    endcase
    case (rx_sel)
      SRC_T1:  rx_src = t1_ovf;
      SRC_T2:  rx_src = t2_ovf;
      SRC_BRG: rx_src = brg_tick;
      default: rx_src = 1'b0;
    endcase
    if (st_r.cfg.serial_mode == SMODE_0) begin
      tx_term = div_term(DIV_MODE0, st_r.cfg.doubler);
    end else if (tx_sel == SRC_T2) begin
      tx_term = DIV_T2;                     // No doubler
    end else begin
      tx_term = div_term(DIV_ASYNC, st_r.cfg.doubler);
    end
    if (st_r.cfg.serial_mode == SMODE_0) begin
      rx_term = tx_term;
    end else if (rx_sel == SRC_T2) begin
      rx_term = DIV_T2;
    end else begin
      rx_term = div_term(DIV_ASYNC, st_r.cfg.doubler);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and pin synchroniser

  always_comb begin
    st_nxt          = st_r;
    st_nxt.pin_sync = {st_r.pin_sync[0], t1_pin};
    st_nxt.pin_prev = st_r.pin_sync[1];
    // Setup cycle: latch the decode and clear the read word
    if (psel && !penable) begin
      st_nxt.slverr = !hit;
      st_nxt.rdata  = ZERO_WORD;
    end
    // Read mux: mapped words only, fields in their low bits
    if (rd && hit) begin
      case (paddr)
        ADDR_TMR_MODE:  st_nxt.rdata[7:4] = st_r.cfg.t1_mode_nib;
        ADDR_PWR_CTRL:  st_nxt.rdata[DOUBLER_BIT] = st_r.cfg.doubler;
        ADDR_T1_CTRL: begin
          st_nxt.rdata[T1_RUN_BIT] = st_r.cfg.t1_run;
          st_nxt.rdata[T1_EXT_BIT] = st_r.cfg.t1_ext;
          st_nxt.rdata[TPS_LSB +: 3] = st_r.cfg.prescale;
        end
        ADDR_T2_CTRL: begin
          st_nxt.rdata[T2_RUN_BIT]   = st_r.cfg.t2_run;
          st_nxt.rdata[T2_TXSEL_BIT] = st_r.cfg.t2_tx_sel;
          st_nxt.rdata[T2_RXSEL_BIT] = st_r.cfg.t2_rx_sel;
        end
        ADDR_T2_CAP:    st_nxt.rdata[15:0] = st_r.cfg.t2_cap;
        ADDR_UART_CTRL: begin
          st_nxt.rdata[NINTH_BIT]      = st_r.cfg.ninth_tx_bit;
          st_nxt.rdata[SMODE_LSB +: 2] = st_r.cfg.serial_mode;
          st_nxt.rdata[BRG_TX_BIT]     = st_r.cfg.brg_tx_sel;
          st_nxt.rdata[BRG_RX_BIT]     = st_r.cfg.brg_rx_sel;
        end
        default: begin                      // Status: live sources
          st_nxt.rdata[1:0] = tx_sel;
          st_nxt.rdata[3:2] = rx_sel;
          st_nxt.rdata[4]   = st_r.pin_sync[1];
        end
      endcase
    end
    // Writes land at the access edge; refused words are never stored
    if (wr && hit) begin
      case (paddr)
        ADDR_TMR_MODE:  st_nxt.cfg.t1_mode_nib = pwdata[T1_MODE_LSB +: 4];
        ADDR_PWR_CTRL:  st_nxt.cfg.doubler = pwdata[DOUBLER_BIT];
        ADDR_T1_CTRL: begin
          st_nxt.cfg.t1_run   = pwdata[T1_RUN_BIT];
          st_nxt.cfg.t1_ext   = pwdata[T1_EXT_BIT];
          st_nxt.cfg.prescale = pwdata[TPS_LSB +: 3];
        end
        ADDR_T2_CTRL: begin
          st_nxt.cfg.t2_run    = pwdata[T2_RUN_BIT];
          st_nxt.cfg.t2_tx_sel = pwdata[T2_TXSEL_BIT];
          st_nxt.cfg.t2_rx_sel = pwdata[T2_RXSEL_BIT];
        end
        ADDR_T2_CAP:    st_nxt.cfg.t2_cap = pwdata[15:0];
        ADDR_UART_CTRL: begin
          st_nxt.cfg.ninth_tx_bit = pwdata[NINTH_BIT];
          st_nxt.cfg.serial_mode  = pwdata[SMODE_LSB +: 2];
          st_nxt.cfg.brg_tx_sel   = pwdata[BRG_TX_BIT];
          st_nxt.cfg.brg_rx_sel   = pwdata[BRG_RX_BIT];
        end
        default: st_nxt.cfg = st_r.cfg;     // Status is read only
      endcase
    end
  end

  // Reset: every field clears, so both directions start in mode 0
  // with the ninth bit clear, both timers stopped and the doubler
  // off; no tick leaves the block until software programs a source.
  // Doubler and all controls clear at reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers and per-direction dividers

  // Timers see only registered configuration, so a write takes effect
  // one cycle after its access edge.
  // Timer 2 loads the capture word while stopped, so the first period
  // after it starts is already a full reload period.
  baud_timer_core u_timers (
    .mclk     (mclk),
    .nrst     (nrst),
    .cfg      (st_r.cfg),
    .t1_event (t1_event),
    .t1_ovf   (t1_ovf),
    .t2_ovf   (t2_ovf)
  );

  // Transmit divider
  baud_div u_tx_div (
    .mclk      (mclk),
    .nrst      (nrst),
    .src_pulse (tx_src),
    .term      (tx_term),
    .bit_tick  (tx_bit_tick)
  );

  // Receive divider runs apart from transmit
  baud_div u_rx_div (
    .mclk      (mclk),
    .nrst      (nrst),
    .src_pulse (rx_src),
    .term      (rx_term),
    .bit_tick  (rx_bit_tick)
  );

endmodule : uart_baud_timer_select

// [testbench/baud_sel_asserts.sv]
// Checker for the baud source selection block, bound to its top ports.
// Assumes one mclk domain and the zero-wait APB slave of the hand-over.
`timescale 1ns/1ps
module baud_sel_asserts
  import baud_sel_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // APB and pins
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        t1_pin,
  input wire logic        brg_tick,
  input wire logic        tx_bit_tick,
  input wire logic        rx_bit_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic       dbl_r;
  logic [7:0] t2c_r;
  logic [7:0] uc_r;
  logic [1:0] src_exp;
  logic       wr_acc;
  //////////////////////////////////////////////////////////////////////
  // Shadow of the fields the status and doubler reads must reflect
  assign wr_acc = psel && penable && pwrite;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dbl_r <= 1'b0;
      t2c_r <= 8'h00;
      uc_r  <= 8'h00;
    end else begin
      if (wr_acc && paddr == ADDR_PWR_CTRL) dbl_r <= pwdata[DOUBLER_BIT];
      if (wr_acc && paddr == ADDR_T2_CTRL) t2c_r <= pwdata[7:0];
      if (wr_acc && paddr == ADDR_UART_CTRL) uc_r <= pwdata[7:0];
    end
  end
  // Generator beats Timer 2, Timer 2 beats Timer 1
  always_comb begin
    if (uc_r[2:1] == SMODE_0) src_exp = uc_r[0] ? 2'h1 : 2'h0;
    else if (uc_r[BRG_TX_BIT]) src_exp = 2'h3;
    else if (t2c_r[T2_TXSEL_BIT]) src_exp = 2'h2;
    else src_exp = 2'h1;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  //////////////////////////////////////////////////////////////////////
  pready_high_a: assert property (pready)
    else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  err_map_a: assert property (psel && penable && paddr > ADDR_STATUS
    |-> pslverr) else $error("unmapped not refused");
  ok_map_a: assert property (psel && penable && paddr <= ADDR_STATUS &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
  dbl_read_a: assert property (setup_s ##1 rd_s(ADDR_PWR_CTRL)
    |-> prdata[DOUBLER_BIT] == dbl_r) else $error("doubler read wrong");
  tx_src_a: assert property (setup_s ##1 rd_s(ADDR_STATUS)
    ##0 uc_r[2:1] != 2'h2 |-> prdata[1:0] == src_exp)
    else $error("tx source wrong");
  tx_pulse_a: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("tx tick too long");
  rx_pulse_a: assert property (rx_bit_tick |=> (!rx_bit_tick)[*2])
    else $error("rx tick too long");
endmodule : baud_sel_asserts

bind uart_baud_timer_select baud_sel_asserts chk_u (
  .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .t1_pin(t1_pin),
  .brg_tick(brg_tick), .tx_bit_tick(tx_bit_tick),
  .rx_bit_tick(rx_bit_tick));

// [testbench/tick_meter.sv]
// Bit-timing partner: measures cycles between successive bit ticks.
// Assumes ticks are one-cycle pulses on mclk.
`timescale 1ns/1ps
module tick_meter (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Tick in, measurement out
  input wire logic tick,
  output int       period,
  output int       count
);
  int cnt_r;
  // Each direction gets its own meter, so the chains are seen apart
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 0;
      period <= 0;
      count  <= 0;
    end else if (tick) begin
      period <= cnt_r + 1;
      cnt_r  <= 0;
      count  <= count + 1;
    end else cnt_r <= cnt_r + 1;
  end
endmodule : tick_meter

// [testbench/test_uart_baud_timer_select.sv]
// Self-checking bench: programs sources over APB, measures tick periods.
// Assumes reload byte stays 0, so Timer 1 overflows every 256 counts.
`timescale 1ns/1ps
module test_uart_baud_timer_select;
  import baud_sel_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, t1_pin = 1'b0, brg_tick = 1'b0, pin_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tx_bit_tick, rx_bit_tick;
  logic [1:0] ph = 2'h0;
  int num_errors = 0, cmp_count = 0, tx_per, tx_cnt, rx_per, rx_cnt;
  always #2.5 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////
  uart_baud_timer_select dut_u (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .t1_pin(t1_pin),
    .brg_tick(brg_tick), .tx_bit_tick(tx_bit_tick),
    .rx_bit_tick(rx_bit_tick));
  tick_meter tx_m (.mclk(mclk), .nrst(nrst), .tick(tx_bit_tick),
    .period(tx_per), .count(tx_cnt));
  tick_meter rx_m (.mclk(mclk), .nrst(nrst), .tick(rx_bit_tick),
    .period(rx_per), .count(rx_cnt));
  // Generator beat every 4 cycles; count pin rises every 4 when enabled
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    brg_tick <= (ph == 2'h3);
    t1_pin <= pin_en & ph[1];
  end
  //////////////////////////////////////////////////////////////////////
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  // One APB transfer; a spare edge first keeps psel from a double write
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No cycle limit here: only the watchdog ends a hung transfer
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  // Period of the latest tick once each direction has ticked three times, so old settings are flushed
  task automatic meas(input int etx, input int erx);
    int t0, r0, n;
    @(posedge mclk);
    t0 = tx_cnt; r0 = rx_cnt; n = 0;
    while ((tx_cnt < t0 + 3 || rx_cnt < r0 + 3) && n < 60000) begin
      @(posedge mclk);
      n++;
    end
    chk(n < 60000, "tick timeout");
    chk(tx_per == etx, "tx period");
    chk(rx_per == erx, "rx period");
  endtask : meas
  //////////////////////////////////////////////////////////////////////
  task t_regs;
    bus(0, ADDR_PWR_CTRL, 0); chk(rd === 32'h0, "doubler reset");
    bus(1, 8'h1c, 32'h1); chk(err === 1'b1, "unmapped write");
    bus(1, ADDR_STATUS, 32'hff);
    bus(0, ADDR_STATUS, 0); chk(rd === 32'h0, "status reset");
    bus(1, ADDR_PWR_CTRL, 32'h80);
    bus(0, ADDR_PWR_CTRL, 0); chk(rd === 32'h80, "doubler rb");
  endtask : t_regs
  task t_t1;
    bus(1, ADDR_TMR_MODE, 32'h20);
    bus(1, ADDR_T1_CTRL, 32'h01);
    bus(1, ADDR_UART_CTRL, 32'h02);
    meas(4096, 4096);
    bus(1, ADDR_T1_CTRL, 32'h11);
    meas(8192, 8192);
  endtask : t_t1
  task t_t2;
    bus(1, ADDR_T2_CAP, 32'hfff0);
    bus(1, ADDR_T1_CTRL, 32'h01);
    bus(1, ADDR_T2_CTRL, 32'h14);
    meas(256, 4096);
    bus(1, ADDR_T2_CTRL, 32'h24);
    meas(4096, 256);
    bus(0, ADDR_STATUS, 0); chk(rd[3:0] === 4'h9, "split status");
  endtask : t_t2
  task t_brg;
    bus(1, ADDR_T2_CTRL, 32'h34);
    bus(1, ADDR_UART_CTRL, 32'h0a);
    meas(64, 256);
    bus(0, ADDR_STATUS, 0); chk(rd[3:0] === 4'hb, "brg status");
  endtask : t_brg
  task t_mode0;
    bus(1, ADDR_PWR_CTRL, 32'h0);
    bus(1, ADDR_UART_CTRL, 32'h01);
    meas(1024, 1024);
    pin_en <= 1'b1;
    bus(1, ADDR_T1_CTRL, 32'h03);
    meas(4096, 4096);
  endtask : t_mode0
  //////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_regs;
    t_t1;
    t_t2;
    t_brg;
    t_mode0;
    end_sim;
  end
  // Watchdog at about 150k cycles, about twice the ~78k the tests need
  initial begin
    #750_000;
    num_errors++;
    end_sim;
  end
endmodule : test_uart_baud_timer_select
